/* File: design/qseq_pkg.sv */
// constants and carrier types of the status and error-queue block
// assumes one clock and an upstream parser that rounds every argument
package qseq_pkg;

    // ****************
    // widths and field positions
    // ****************
    localparam int REG_W = 16;
    localparam int RANGE_MAX = 6;
    localparam int RANGE_CW = 3;
    localparam int DESC_W = 8;
    localparam int BIT_FREQ = 9;
    localparam int BIT_OVLD = 11;
    localparam int QUEUE_DEPTH_DEF = 8;

    // ****************
    // reset and preset values
    // ****************
    localparam logic [REG_W-1:0] PRESET_PTR = 16'h7FFF;
    localparam logic [REG_W-1:0] PRESET_NTR = 16'h0000;
    localparam logic [REG_W-1:0] PRESET_ENA = 16'h0000;
    localparam logic [REG_W-1:0] PRESET_LO = 16'hFE48;
    localparam logic [REG_W-1:0] PRESET_HI = 16'hFF9C;
    localparam logic [REG_W-1:0] NO_ERROR_NUM = 16'h0000;
    localparam logic [DESC_W-1:0] NO_ERROR_DESC = 8'h00;

    // ****************
    // commands and states
    // ****************
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_QUE_READ = 4'h1,
        OP_QUE_ENA_CLEAR = 4'h2,
        OP_QUE_ENA_ADD = 4'h3,
        OP_QUE_ENA_READ = 4'h4,
        OP_COND_READ = 4'h5,
        OP_PTR_WRITE = 4'h6,
        OP_PTR_READ = 4'h7,
        OP_NTR_WRITE = 4'h8,
        OP_NTR_READ = 4'h9,
        OP_EVENT_READ = 4'hA,
        OP_ENA_WRITE = 4'hB,
        OP_ENA_READ = 4'hC,
        OP_PRESET = 4'hD
    } qseq_op_type;

    typedef enum logic {
        S_BOOT = 1'b0,
        S_RUN = 1'b1
    } qseq_fsm_type;

    // ****************
    // carriers
    // ****************
    typedef struct packed {
        logic [RANGE_CW-1:0] count;
        logic [RANGE_MAX-1:0] used;
        logic [RANGE_MAX-1:0][REG_W-1:0] lo;
        logic [RANGE_MAX-1:0][REG_W-1:0] hi;
    } qseq_ranges_type;

    typedef struct packed {
        logic [REG_W-1:0] ptr;
        logic [REG_W-1:0] ntr;
        logic [REG_W-1:0] ena;
        logic [REG_W-1:0] event_bits;
    } qseq_keep_type;

    typedef struct packed {
        logic [REG_W-1:0] cond;
        logic [REG_W-1:0] ptr;
        logic [REG_W-1:0] ntr;
        logic [REG_W-1:0] event_bits;
        logic [REG_W-1:0] ena;
        logic summary;
    } qseq_chan_type;

    typedef struct packed {
        logic [REG_W-1:0] num;
        logic [DESC_W-1:0] desc;
    } qseq_err_type;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [REG_W-1:0] data2;
        logic [DESC_W-1:0] desc;
    } qseq_rsp_type;

endpackage

/* File: design/qseq_fifo.sv */
// error queue storage: a plain first-in first-out list of error entries
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module qseq_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] push_data_in,
    input wire logic pop_in,
    output logic [WIDTH-1:0] head_out,
    output logic empty_out,
    output logic full_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
    } qseq_fifo_state_type;

    qseq_fifo_state_type st;
    qseq_fifo_state_type next_st;
    logic do_push;
    logic do_pop;

    // a full queue drops the newest entry rather than losing an old one
    always_comb begin
        next_st = st;
        do_pop = pop_in && (st.count != '0);
        do_push = push_in && ((st.count != FULL_COUNT) || do_pop);
        if (do_push) begin
            next_st.mem[st.wr] = push_data_in;
            next_st.wr = (st.wr == LAST) ? '0 : AW'(st.wr + 1'b1);
        end
        if (do_pop) begin
            next_st.rd = (st.rd == LAST) ? '0 : AW'(st.rd + 1'b1);
        end
        if (do_push && !do_pop) begin
            next_st.count = (AW + 1)'(st.count + 1'b1);
        end else if (do_pop && !do_push) begin
            next_st.count = (AW + 1)'(st.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign head_out = st.mem[st.rd];
    assign empty_out = (st.count == '0);
    assign full_out = (st.count == FULL_COUNT);
endmodule

/* File: design/qseq_chan.sv */
// one channel's questionable-status set: condition, two transition filters, event, enable
// assumes the condition word is already synchronised to the clock
`timescale 1ns/1ps
module qseq_chan (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [qseq_pkg::REG_W-1:0] cond_in,
    input wire logic load_in,
    input wire qseq_pkg::qseq_keep_type keep_in,
    input wire logic preset_in,
    input wire logic wipe_in,
    input wire logic ptr_wr_in,
    input wire logic ntr_wr_in,
    input wire logic ena_wr_in,
    input wire logic ev_clr_in,
    input wire logic [qseq_pkg::REG_W-1:0] wdata_in,
    output qseq_pkg::qseq_chan_type state_out
);
    qseq_pkg::qseq_chan_type st;
    qseq_pkg::qseq_chan_type next_st;
    logic [qseq_pkg::REG_W-1:0] rise;
    logic [qseq_pkg::REG_W-1:0] fall;
    logic [qseq_pkg::REG_W-1:0] ev_base;

    // edge filtering and register updates
    always_comb begin
        next_st = st;
        next_st.cond = cond_in;
        rise = cond_in & ~st.cond;
        fall = ~cond_in & st.cond;
        ev_base = (ev_clr_in || wipe_in) ? '0 : st.event_bits;
        if (load_in) begin
            next_st.ptr = keep_in.ptr;
            next_st.ntr = keep_in.ntr;
            next_st.ena = keep_in.ena;
            ev_base = keep_in.event_bits;
        end else if (preset_in) begin
            next_st.ptr = qseq_pkg::PRESET_PTR;
            next_st.ntr = qseq_pkg::PRESET_NTR;
            next_st.ena = qseq_pkg::PRESET_ENA;
        end else begin
            if (ptr_wr_in) next_st.ptr = wdata_in;
            if (ntr_wr_in) next_st.ntr = wdata_in;
            if (ena_wr_in) next_st.ena = wdata_in;
        end
        // set wins over the read clear so no edge is lost; bits stick until read
        next_st.event_bits = ev_base | (rise & st.ptr) | (fall & st.ntr);
        next_st.summary = |(next_st.event_bits & next_st.ena);
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign state_out = st;
endmodule

/* File: design/qseq_top.sv */
// questionable-status structure and filtered error queue
// assumes a parser giving one-cycle requests, and a retained store
// that keeps NV_*_OUT across power-down and offers it back
//
// Functional notes
// - queue read answers the oldest entry, number and description, then drops it
// - an error is queued only if its number lies in an enabled range
// - power-on-clear flag set: status cleared, only -440..-100 enabled
// - power-on-clear flag clear: retained status and enable ranges restored
// - up to six ranges per enable setting, all of them stored
// - frequency conflict and overload reported separately per channel
// - five 16-bit registers per channel, one condition per bit
// - bit 9 is frequency conflict, bit 11 is overload, rest unused
// - condition register follows live conditions and is read-only
// - false-to-true edge with rising filter bit set sets the event bit
// - true-to-false edge with falling filter bit set sets the event bit
// - summary bit high while any event bit meets its enable bit
// - event read returns contents and then clears every bit not set again by an edge in that cycle
// - filter and enable writes take values 0..131072; only the low 16 bits are stored, so 131072 reads back as 0
// - filters and enable read back as stored integers
// - preset clears enable, filters to 7FFF and zero, default ranges
`timescale 1ns/1ps
module qseq_top #(
    parameter int NUM_CH = 2,
    parameter int CH_W = 1,
    parameter int QUEUE_DEPTH = qseq_pkg::QUEUE_DEPTH_DEF
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic PSC_FLAG_IN,
    input wire qseq_pkg::qseq_ranges_type NV_RANGES_IN,
    input wire qseq_pkg::qseq_keep_type [NUM_CH-1:0] NV_CHAN_IN,
    input wire logic [NUM_CH-1:0] COND_FREQ_IN,
    input wire logic [NUM_CH-1:0] COND_OVLD_IN,
    input wire logic ERR_VALID_IN,
    input wire logic [qseq_pkg::REG_W-1:0] ERR_NUM_IN,
    input wire logic [qseq_pkg::DESC_W-1:0] ERR_DESC_IN,
    input wire logic CMD_VALID_IN,
    input wire qseq_pkg::qseq_op_type CMD_OP_IN,
    input wire logic [CH_W-1:0] CMD_CHAN_IN,
    input wire logic [31:0] CMD_DATA_IN,
    input wire logic [qseq_pkg::REG_W-1:0] CMD_HI_IN,
    output logic READY_OUT,
    output qseq_pkg::qseq_rsp_type RSP_OUT,
    output logic QUES_SUMMARY_OUT,
    output qseq_pkg::qseq_ranges_type NV_RANGES_OUT,
    output qseq_pkg::qseq_keep_type [NUM_CH-1:0] NV_CHAN_OUT
);
    localparam int ERR_W = $bits(qseq_pkg::qseq_err_type);

    // ****************
    // state and local types
    // ****************
    typedef struct packed {
        qseq_pkg::qseq_fsm_type fsm;
        logic ready;
        qseq_pkg::qseq_ranges_type ranges;
        qseq_pkg::qseq_rsp_type rsp;
        logic summary;
        logic [NUM_CH-1:0] freq_meta;
        logic [NUM_CH-1:0] freq_sync;
        logic [NUM_CH-1:0] ovld_meta;
        logic [NUM_CH-1:0] ovld_sync;
    } qseq_top_state_type;

    qseq_top_state_type st;
    qseq_top_state_type next_st;

    qseq_pkg::qseq_chan_type [NUM_CH-1:0] chan_st;
    logic [NUM_CH-1:0] ch_load;
    logic [NUM_CH-1:0] ch_preset;
    logic [NUM_CH-1:0] ch_wipe;
    logic [NUM_CH-1:0] ch_ptr_wr;
    logic [NUM_CH-1:0] ch_ntr_wr;
    logic [NUM_CH-1:0] ch_ena_wr;
    logic [NUM_CH-1:0] ch_ev_clr;
    logic [qseq_pkg::REG_W-1:0] wdata;
    logic [NUM_CH-1:0] sel_hot;
    logic chan_ok;
    qseq_pkg::qseq_chan_type sel_st;
    logic [qseq_pkg::REG_W-1:0] sel_hi;
    logic [qseq_pkg::REG_W-1:0] sel_lo;
    logic [qseq_pkg::RANGE_CW-1:0] rng_idx;
    logic q_push;
    logic q_pop;
    logic q_empty;
    qseq_pkg::qseq_err_type q_head;
    logic [ERR_W-1:0] q_head_bits;

    // ****************
    // helper functions
    // ****************

    // enable set loaded at preset and at a clearing power-up
    function automatic qseq_pkg::qseq_ranges_type default_ranges();
        qseq_pkg::qseq_ranges_type r;
        r = '0;
        r.count = qseq_pkg::RANGE_CW'(1);
        r.used[0] = 1'b1;
        r.lo[0] = qseq_pkg::PRESET_LO;
        r.hi[0] = qseq_pkg::PRESET_HI;
        return r;
    endfunction

    // signed membership test over all stored ranges
    function automatic logic num_enabled(input qseq_pkg::qseq_ranges_type r,
                                         input logic [qseq_pkg::REG_W-1:0] n);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < qseq_pkg::RANGE_MAX; i++) begin
            if (r.used[i] && ($signed(n) >= $signed(r.lo[i]))
                && ($signed(n) <= $signed(r.hi[i]))) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // one-hot channel select; an out-of-range channel selects none
    function automatic logic [NUM_CH-1:0] chan_hot(input logic [CH_W-1:0] c);
        logic [NUM_CH-1:0] h;
        h = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (int'(c) == i) h[i] = 1'b1;
        end
        return h;
    endfunction

    // ****************
    // channel register sets
    // ****************

    // each channel owns its own five registers
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
            logic [qseq_pkg::REG_W-1:0] cond_word;

            // only two bit positions carry live conditions
            always_comb begin
                cond_word = '0;
                cond_word[qseq_pkg::BIT_FREQ] = st.freq_sync[g];
                cond_word[qseq_pkg::BIT_OVLD] = st.ovld_sync[g];
            end

            qseq_chan u_chan (
                .clk_in(CLOCK_IN),
                .rst_in(RST_IN),
                .cond_in(cond_word),
                .load_in(ch_load[g]),
                .keep_in(NV_CHAN_IN[g]),
                .preset_in(ch_preset[g]),
                .wipe_in(ch_wipe[g]),
                .ptr_wr_in(ch_ptr_wr[g]),
                .ntr_wr_in(ch_ntr_wr[g]),
                .ena_wr_in(ch_ena_wr[g]),
                .ev_clr_in(ch_ev_clr[g]),
                .wdata_in(wdata),
                .state_out(chan_st[g])
            );

            assign NV_CHAN_OUT[g].ptr = chan_st[g].ptr;
            assign NV_CHAN_OUT[g].ntr = chan_st[g].ntr;
            assign NV_CHAN_OUT[g].ena = chan_st[g].ena;
            assign NV_CHAN_OUT[g].event_bits = chan_st[g].event_bits;
        end
    endgenerate

    // ****************
    // error queue
    // ****************

    qseq_fifo #(
        .WIDTH(ERR_W),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .push_in(q_push),
        .push_data_in({ERR_NUM_IN, ERR_DESC_IN}),
        .pop_in(q_pop),
        .head_out(q_head_bits),
        .empty_out(q_empty),
        .full_out()
    );

    assign q_head = q_head_bits;
    // errors arriving before the enable set is settled are not queued
    assign q_push = ERR_VALID_IN && st.ready && num_enabled(st.ranges, ERR_NUM_IN);

    // ****************
    // command decode and next state
    // ****************

    // selected channel view and range slot for reads
    always_comb begin
        sel_hot = chan_hot(CMD_CHAN_IN);
        chan_ok = |sel_hot;
        sel_st = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (sel_hot[i]) sel_st = chan_st[i];
        end
        rng_idx = CMD_DATA_IN[qseq_pkg::RANGE_CW-1:0];
        sel_lo = '0;
        sel_hi = '0;
        if (int'(rng_idx) < qseq_pkg::RANGE_MAX) begin
            sel_lo = st.ranges.lo[rng_idx];
            sel_hi = st.ranges.hi[rng_idx];
        end
    end

    // main sequencing: boot-time restore, then one command per cycle
    always_comb begin
        next_st = st;
        ch_load = '0;
        ch_preset = '0;
        ch_wipe = '0;
        ch_ptr_wr = '0;
        ch_ntr_wr = '0;
        ch_ena_wr = '0;
        ch_ev_clr = '0;
        q_pop = 1'b0;
        wdata = CMD_DATA_IN[qseq_pkg::REG_W-1:0];
        next_st.rsp = '0;
        // two-stage synchronisers for the condition pins
        next_st.freq_meta = COND_FREQ_IN;
        next_st.freq_sync = st.freq_meta;
        next_st.ovld_meta = COND_OVLD_IN;
        next_st.ovld_sync = st.ovld_meta;
        next_st.summary = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            next_st.summary = next_st.summary | chan_st[i].summary;
        end
        case (st.fsm)
            qseq_pkg::S_BOOT: begin
                // the retained flag is sampled once, in the first cycle after reset
                if (PSC_FLAG_IN) begin
                    next_st.ranges = default_ranges();
                    ch_preset = '1;
                    ch_wipe = '1;
                end else begin
                    next_st.ranges = NV_RANGES_IN;
                    ch_load = '1;
                end
                next_st.fsm = qseq_pkg::S_RUN;
                next_st.ready = 1'b1;
            end
            qseq_pkg::S_RUN: begin
                if (CMD_VALID_IN) begin
                    next_st.rsp.valid = 1'b1;
                    case (CMD_OP_IN)
                        qseq_pkg::OP_QUE_READ: begin
                            // an empty queue answers the no-error entry
                            if (!q_empty) begin
                                next_st.rsp.data = {{16{q_head.num[15]}}, q_head.num};
                                next_st.rsp.desc = q_head.desc;
                                q_pop = 1'b1;
                            end else begin
                                next_st.rsp.data = {16'h0000, qseq_pkg::NO_ERROR_NUM};
                                next_st.rsp.desc = qseq_pkg::NO_ERROR_DESC;
                            end
                        end
                        qseq_pkg::OP_QUE_ENA_CLEAR: begin
                            next_st.ranges = '0;
                        end
                        qseq_pkg::OP_QUE_ENA_ADD: begin
                            // a reversed pair is dropped; a seventh entry is ignored
                            if ((int'(st.ranges.count) < qseq_pkg::RANGE_MAX)
                                && ($signed(wdata) <= $signed(CMD_HI_IN))) begin
                                next_st.ranges.used[st.ranges.count] = 1'b1;
                                next_st.ranges.lo[st.ranges.count] = wdata;
                                next_st.ranges.hi[st.ranges.count] = CMD_HI_IN;
                                next_st.ranges.count = qseq_pkg::RANGE_CW'(st.ranges.count + 1'b1);
                            end
                        end
                        qseq_pkg::OP_QUE_ENA_READ: begin
                            next_st.rsp.data = {{16{sel_lo[15]}}, sel_lo};
                            next_st.rsp.data2 = sel_hi;
                            next_st.rsp.desc = qseq_pkg::DESC_W'(st.ranges.count);
                        end
                        qseq_pkg::OP_COND_READ: begin
                            next_st.rsp.data = {16'h0000, sel_st.cond};
                        end
                        qseq_pkg::OP_PTR_WRITE: begin
                            ch_ptr_wr = sel_hot;
                        end
                        qseq_pkg::OP_PTR_READ: begin
                            next_st.rsp.data = {16'h0000, sel_st.ptr};
                        end
                        qseq_pkg::OP_NTR_WRITE: begin
                            ch_ntr_wr = sel_hot;
                        end
                        qseq_pkg::OP_NTR_READ: begin
                            next_st.rsp.data = {16'h0000, sel_st.ntr};
                        end
                        qseq_pkg::OP_EVENT_READ: begin
                            next_st.rsp.data = {16'h0000, sel_st.event_bits};
                            ch_ev_clr = sel_hot;
                        end
                        qseq_pkg::OP_ENA_WRITE: begin
                            ch_ena_wr = sel_hot;
                        end
                        qseq_pkg::OP_ENA_READ: begin
                            next_st.rsp.data = {16'h0000, sel_st.ena};
                        end
                        qseq_pkg::OP_PRESET: begin
                            ch_preset = '1;
                            next_st.ranges = default_ranges();
                        end
                        default: begin
                            next_st.rsp.valid = 1'b1;
                        end
                    endcase
                    // a channel outside the fitted set reads as zero
                    if (!chan_ok && (CMD_OP_IN != qseq_pkg::OP_QUE_READ)
                        && (CMD_OP_IN != qseq_pkg::OP_QUE_ENA_READ)) begin
                        next_st.rsp.data = '0;
                    end
                end
            end
            default: begin
                next_st.fsm = qseq_pkg::S_BOOT;
                next_st.ready = 1'b0;
            end
        endcase
    end

    // ****************
    // state register and outputs
    // ****************

    // synchronous reset to constants only; restore happens in the boot cycle
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign READY_OUT = st.ready;
    assign RSP_OUT = st.rsp;
    assign QUES_SUMMARY_OUT = st.summary;
    assign NV_RANGES_OUT = st.ranges;
endmodule

/* File: sim/qseq_asserts.sv */
// checker: answers, read-back, events and summary of qseq_top
// assumes a bind onto qseq_top; sees its ports only
`timescale 1ns/1ps
module qseq_asserts #(parameter int NUM_CH = 2, parameter int CH_W = 1) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic CMD_VALID_IN,
    input wire qseq_pkg::qseq_op_type CMD_OP_IN,
    input wire logic [CH_W-1:0] CMD_CHAN_IN,
    input wire logic [NUM_CH-1:0] COND_OVLD_IN,
    input wire logic READY_OUT,
    input wire qseq_pkg::qseq_rsp_type RSP_OUT,
    input wire logic QUES_SUMMARY_OUT,
    input wire qseq_pkg::qseq_keep_type [NUM_CH-1:0] NV_CHAN_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    // channel-0 request taken; event&enable over all channels
    logic tk;
    logic [15:0] hit;
    assign tk = CMD_VALID_IN && READY_OUT && CMD_CHAN_IN == '0;
    always_comb begin
        hit = 16'h0000;
        for (int i = 0; i < NUM_CH; i++) begin
            hit = hit | (NV_CHAN_OUT[i].event_bits & NV_CHAN_OUT[i].ena);
        end
    end
    answer_a: assert property (CMD_VALID_IN && READY_OUT |=> RSP_OUT.valid)
        else $error("no answer");
    ptr_read_a: assert property (tk && CMD_OP_IN == qseq_pkg::OP_PTR_READ
        |=> RSP_OUT.data == {16'h0000, $past(NV_CHAN_OUT[0].ptr)}) else $error("ptr read");
    event_read_a: assert property (tk && CMD_OP_IN == qseq_pkg::OP_EVENT_READ
        |=> RSP_OUT.data[15:0] == $past(NV_CHAN_OUT[0].event_bits)) else $error("event read");
    cond_bits_a: assert property (tk && CMD_OP_IN == qseq_pkg::OP_COND_READ
        |=> (RSP_OUT.data & 32'hFFFFF5FF) == 32'h00000000) else $error("cond bits");
    preset_a: assert property (tk && CMD_OP_IN == qseq_pkg::OP_PRESET
        |=> NV_CHAN_OUT[0].ptr == 16'h7FFF && NV_CHAN_OUT[0].ena == 16'h0000) else $error("preset");
    summary_a: assert property (READY_OUT && $past(READY_OUT)
        |-> QUES_SUMMARY_OUT == $past(|hit)) else $error("summary");
    rise_event_a: assert property ($rose(COND_OVLD_IN[0]) && NV_CHAN_OUT[0].ptr[11]
        |-> ##[4:5] NV_CHAN_OUT[0].event_bits[11]) else $error("rise event");
    fall_event_a: assert property ($fell(COND_OVLD_IN[0]) && NV_CHAN_OUT[0].ntr[11]
        |-> ##[4:5] NV_CHAN_OUT[0].event_bits[11]) else $error("fall event");
    rise_c: cover property ($rose(NV_CHAN_OUT[0].event_bits[11]));
    summary_c: cover property ($rose(QUES_SUMMARY_OUT));
    preset_c: cover property (tk && CMD_OP_IN == qseq_pkg::OP_PRESET);
endmodule
bind qseq_top qseq_asserts #(.NUM_CH(NUM_CH), .CH_W(CH_W)) asserts_u (.*);

/* File: sim/qseq_host.sv */
// host controller model: one status command per call
// assumes the bench waits for ready before the first call
`timescale 1ns/1ps
module qseq_host (
    input wire logic clk_in,
    output logic cmd_valid_out = 1'b0,
    output qseq_pkg::qseq_op_type cmd_op_out = qseq_pkg::OP_NOP,
    output logic cmd_chan_out = 1'b0,
    output logic [31:0] cmd_data_out = 32'h00000000
);
    // values already rounded, within 0..131072, ranges given low first
    task automatic send(input qseq_pkg::qseq_op_type o, input logic c, input logic [31:0] d);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_op_out <= o;
        cmd_chan_out <= c;
        cmd_data_out <= d;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_data_out <= ~d; // release shows the inverse
    endtask
endmodule

/* File: sim/qseq_top_bench.sv */
// bench for qseq_top: rows, queue, events, retention, preset
// assumes qseq_host drives commands; range hi = low data bits
`timescale 1ns/1ps
module qseq_top_bench;
    typedef struct {qseq_pkg::qseq_op_type o; logic c; logic [31:0] d, e;} qseq_row_type;
    logic clk = 1'b0, rst = 1'b1, psc = 1'b1, err_v = 1'b0, val, ch, rdy, summ;
    logic [15:0] err_n = 16'h0000;
    logic [1:0] c_f = 2'b00, c_o = 2'b00;
    logic [31:0] dat;
    qseq_pkg::qseq_op_type op;
    qseq_pkg::qseq_rsp_type rsp;
    qseq_pkg::qseq_ranges_type nv_r = '0, nr_o;
    qseq_pkg::qseq_keep_type [1:0] nv_c = '0, nc_o;
    int fail_count = 0, compares = 0;
    qseq_row_type rows [7] = '{'{qseq_pkg::OP_PTR_READ, 1'b1, 32'h0, 32'h7FFF},
        '{qseq_pkg::OP_ENA_WRITE, 1'b1, 32'h200, 32'h0}, '{qseq_pkg::OP_ENA_READ, 1'b1, 32'h0, 32'h200},
        '{qseq_pkg::OP_ENA_WRITE, 1'b1, 32'h20000, 32'h0}, '{qseq_pkg::OP_ENA_READ, 1'b1, 32'h0, 32'h0},
        '{qseq_pkg::OP_PTR_WRITE, 1'b0, 32'h800, 32'h0}, '{qseq_pkg::OP_ENA_WRITE, 1'b0, 32'h800, 32'h0}};
    always #12.5 clk = ~clk;
    qseq_host host_u (.clk_in(clk), .cmd_valid_out(val), .cmd_op_out(op), .cmd_chan_out(ch),
        .cmd_data_out(dat));
    qseq_top dut_u (.CLOCK_IN(clk), .RST_IN(rst), .PSC_FLAG_IN(psc), .NV_RANGES_IN(nv_r),
        .NV_CHAN_IN(nv_c), .COND_FREQ_IN(c_f), .COND_OVLD_IN(c_o), .ERR_VALID_IN(err_v),
        .ERR_NUM_IN(err_n), .ERR_DESC_IN(err_n[7:0]), .CMD_VALID_IN(val), .CMD_OP_IN(op),
        .CMD_CHAN_IN(ch), .CMD_DATA_IN(dat), .CMD_HI_IN(dat[15:0]), .READY_OUT(rdy),
        .RSP_OUT(rsp), .QUES_SUMMARY_OUT(summ), .NV_RANGES_OUT(nr_o), .NV_CHAN_OUT(nc_o));
    task automatic chk(input string w, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // answer stands one cycle: look 1 ns after its edge
    task automatic cmd(input qseq_pkg::qseq_op_type o, input logic c, input logic [31:0] d, e);
        host_u.send(o, c, d);
        #1;
        chk("valid", 32'h1, {31'h0, rsp.valid});
        chk("data", e, rsp.data);
    endtask
    task automatic push(input logic [15:0] n);
        @(posedge clk);
        err_v <= 1'b1;
        err_n <= n;
        @(posedge clk);
        err_v <= 1'b0;
    endtask
    // watchdog: about 110 cycles needed, 8000 allowed
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (rows[i]) cmd(rows[i].o, rows[i].c, rows[i].d, rows[i].e);
        $display("rows done");
        push(16'hFF38);
        push(16'hFFCE);
        push(16'hFE48);
        push(16'hFE47);
        cmd(qseq_pkg::OP_QUE_READ, 1'b0, 32'h0, 32'hFFFFFF38);
        chk("desc", 32'h38, {24'h0, rsp.desc});
        cmd(qseq_pkg::OP_QUE_READ, 1'b0, 32'h0, 32'hFFFFFE48);
        cmd(qseq_pkg::OP_QUE_READ, 1'b0, 32'h0, 32'h0);
        cmd(qseq_pkg::OP_QUE_ENA_CLEAR, 1'b0, 32'h0, 32'h0);
        for (int i = 0; i < 7; i++) cmd(qseq_pkg::OP_QUE_ENA_ADD, 1'b0, i, 32'h0);
        cmd(qseq_pkg::OP_QUE_ENA_READ, 1'b0, 32'h5, 32'h5);
        chk("count", 32'h6, {24'h0, rsp.desc});
        chk("hi", 32'h5, {16'h0, rsp.data2});
        push(16'h0006);
        push(16'h0003);
        cmd(qseq_pkg::OP_QUE_READ, 1'b0, 32'h0, 32'h3);
        $display("queue done");
        @(posedge clk);
        c_o <= 2'b01;
        c_f <= 2'b10;
        repeat (8) @(posedge clk);
        chk("summary", 32'h1, {31'h0, summ});
        cmd(qseq_pkg::OP_COND_READ, 1'b0, 32'h0, 32'h800);
        cmd(qseq_pkg::OP_EVENT_READ, 1'b1, 32'h0, 32'h200);
        cmd(qseq_pkg::OP_EVENT_READ, 1'b0, 32'h0, 32'h800);
        cmd(qseq_pkg::OP_NTR_WRITE, 1'b0, 32'h800, 32'h0);
        cmd(qseq_pkg::OP_NTR_READ, 1'b0, 32'h0, 32'h800);
        @(posedge clk);
        c_o <= 2'b00;
        repeat (8) @(posedge clk);
        cmd(qseq_pkg::OP_EVENT_READ, 1'b0, 32'h0, 32'h800);
        cmd(qseq_pkg::OP_EVENT_READ, 1'b0, 32'h0, 32'h0);
        chk("summary", 32'h0, {31'h0, summ});
        $display("events done");
        @(posedge clk);
        nv_r <= nr_o;
        nv_c <= nc_o;
        psc <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ready", 32'h0, {31'h0, rdy});
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("ready", 32'h1, {31'h0, rdy});
        cmd(qseq_pkg::OP_PTR_READ, 1'b0, 32'h0, 32'h800);
        cmd(qseq_pkg::OP_QUE_ENA_READ, 1'b0, 32'h5, 32'h5);
        cmd(qseq_pkg::OP_PRESET, 1'b0, 32'h0, 32'h0);
        cmd(qseq_pkg::OP_ENA_READ, 1'b0, 32'h0, 32'h0);
        $display("retain done");
        tally_and_finish;
    end
endmodule
